// ---- src/umf_modem.sv ----
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
//
// Contract
// [R1] Bit 13 of modem_control reads back the level now driven on the RTS pin and ignores writes.
// [R2] The RTS polarity bit 9 makes RTS active low when 0 and active high when 1.
// [R3] Bit 4 of modem_control enables loopback when 1 and disables it when 0.
// [R4] With auto RTS off, bit 1 drives RTS active (the polarity) when 1, inactive when 0.
// [R5] The CTS polarity bit 8 of modem_status makes CTS active low when 0, active high when 1.
// [R6] Bit 4 of modem_status reads back the synchronised CTS pin level and ignores writes.
// [R7] Bit 0 of modem_status is set whenever the CTS input changes in either direction.
// [R8] A set CTS change flag with the modem interrupt enable at 1 raises the interrupt.
// [R9] Writing 1 to the CTS change flag clears it, writing 0 leaves it unchanged.
// [R10] modem_control at offset 0x10 reads 0x2000 after reset: RTS inactive (pin high), active low, no loopback.
// [R11] modem_status at offset 0x14 resets to zero: flag clear, CTS active low.
// [R12] CTS is synchronised to the clock before edge detection so one change flags once.
// [R13] Loopback feeds transmit into receive internally and holds the pins idle.
module umf_modem
   import umf_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // axi4-lite write address and data
   input wire logic [umf_pkg::UMF_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read
   input wire logic [umf_pkg::UMF_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // modem pins
   output logic RTS_O,
   input wire logic CTS_I,
   // serial pins
   output logic TXD_O,
   input wire logic RXD_I,
   // uart core side
   input wire logic TXD_I,
   output logic RXD_O,
   input wire logic AUTO_RTS_I,
   output logic CTS_ACTIVE_O,
   // interrupt
   output logic IRQ_O
);
   import umf_pkg::*;

   umf_state_s st_r;
   umf_state_s st_nxt;
   logic cts_sync;
   logic rxd_sync;

   function automatic logic reg_sel(input logic [UMF_AW-1:0] addr,
                                    input logic [UMF_AW-1:0] off);
      reg_sel = (addr[UMF_AW-1:2] == off[UMF_AW-1:2]);
   endfunction : reg_sel

   function automatic logic is_mapped(input logic [UMF_AW-1:0] addr);
      is_mapped = reg_sel(addr, UMF_OFF_INT_ENABLE) || reg_sel(addr, UMF_OFF_INT_STATUS)
         || reg_sel(addr, UMF_OFF_INT_CLEAR) || reg_sel(addr, UMF_OFF_MODEM_CONTROL)
         || reg_sel(addr, UMF_OFF_MODEM_STATUS);
   endfunction : is_mapped

   umf_sync #(
      .RST_VAL(1'b0)
   ) u_cts_sync (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .async_i(CTS_I), // R12
      .level_o(cts_sync)
   );

   // rx idles high, so its synchroniser starts there
   umf_sync #(
      .RST_VAL(1'b1)
   ) u_rxd_sync (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .async_i(RXD_I),
      .level_o(rxd_sync)
   );

   always_comb begin
      logic do_wr;
      logic flag_clr;
      logic flag_set;
      logic rts_active;
      logic [31:0] rd;
      st_nxt = st_r;
      do_wr = 1'b0;
      flag_clr = 1'b0;
      flag_set = 1'b0;
      rts_active = 1'b0;
      rd = 32'h0000_0000;

      // write channel: address and data may arrive in either order
      if (st_r.bvalid && S_AXI_BREADY) begin
         st_nxt.bvalid = 1'b0;
      end
      if (S_AXI_AWVALID && st_r.awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && st_r.wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = S_AXI_WDATA;
         st_nxt.wstrb = S_AXI_WSTRB;
      end
      do_wr = st_r.aw_held && st_r.w_held && !st_r.bvalid;
      if (do_wr) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = is_mapped(st_r.awaddr) ? UMF_RESP_OKAY : UMF_RESP_SLVERR;
         if (reg_sel(st_r.awaddr, UMF_OFF_MODEM_CONTROL)) begin
            if (st_r.wstrb[0]) begin
               st_nxt.rts_ctl = st_r.wdata[UMF_MC_RTS_CTL]; // R4
               st_nxt.loopback_enable = st_r.wdata[UMF_MC_LOOPBACK]; // R3
            end
            if (st_r.wstrb[1]) begin
               st_nxt.rts_polarity = st_r.wdata[UMF_MC_RTS_POL]; // R2
            end
         end
         if (reg_sel(st_r.awaddr, UMF_OFF_MODEM_STATUS)) begin
            if (st_r.wstrb[0]) begin
               flag_clr = st_r.wdata[UMF_MS_CTS_FLAG]; // R9
            end
            if (st_r.wstrb[1]) begin
               st_nxt.cts_polarity = st_r.wdata[UMF_MS_CTS_POL]; // R5
            end
         end
         if (reg_sel(st_r.awaddr, UMF_OFF_INT_CLEAR) && st_r.wstrb[0]) begin
            flag_clr = flag_clr | st_r.wdata[UMF_IE_MODEM]; // R9
         end
         if (reg_sel(st_r.awaddr, UMF_OFF_INT_ENABLE)) begin
            if (st_r.wstrb[0]) begin
               st_nxt.modem_interrupt_enable = st_r.wdata[UMF_IE_MODEM];
            end
            if (st_r.wstrb[1]) begin
               st_nxt.auto_rts_enable = st_r.wdata[UMF_IE_AUTO_RTS];
            end
         end
      end
      // no new address or data while a response is still owed
      st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

      // read channel
      if (reg_sel(S_AXI_ARADDR, UMF_OFF_MODEM_CONTROL)) begin
         rd[UMF_MC_RTS_CTL] = st_r.rts_ctl;
         rd[UMF_MC_LOOPBACK] = st_r.loopback_enable; // R3
         rd[UMF_MC_RTS_POL] = st_r.rts_polarity;
         rd[UMF_MC_RTS_LEVEL] = st_r.rts_pin; // R1
      end else if (reg_sel(S_AXI_ARADDR, UMF_OFF_MODEM_STATUS)) begin
         rd[UMF_MS_CTS_FLAG] = st_r.cts_change_flag;
         rd[UMF_MS_CTS_LEVEL] = cts_sync; // R6
         rd[UMF_MS_CTS_POL] = st_r.cts_polarity;
      end else if (reg_sel(S_AXI_ARADDR, UMF_OFF_INT_STATUS)) begin
         rd[UMF_IE_MODEM] = st_r.cts_change_flag;
      end else if (reg_sel(S_AXI_ARADDR, UMF_OFF_INT_ENABLE)) begin
         rd[UMF_IE_MODEM] = st_r.modem_interrupt_enable;
         rd[UMF_IE_AUTO_RTS] = st_r.auto_rts_enable;
      end
      if (st_r.rvalid && S_AXI_RREADY) begin
         st_nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd;
         st_nxt.rresp = is_mapped(S_AXI_ARADDR) ? UMF_RESP_OKAY : UMF_RESP_SLVERR;
      end
      st_nxt.arready = !st_nxt.rvalid;

      // cts change detect, held off until the synchroniser shows the real pin
      if (st_r.settle != UMF_SETTLE_CYCLES) begin
         st_nxt.settle = st_r.settle + 3'h1;
      end else begin
         flag_set = (cts_sync != st_r.cts_prev); // R7 R12
      end
      st_nxt.cts_prev = cts_sync;
      // a change in the clearing cycle is kept
      st_nxt.cts_change_flag = flag_set | (st_r.cts_change_flag & ~flag_clr); // R7 R9
      st_nxt.cts_active = (cts_sync == st_nxt.cts_polarity); // R5

      // rts pin: inactive level is the inverse of the polarity
      rts_active = st_nxt.auto_rts_enable ? AUTO_RTS_I : st_nxt.rts_ctl; // R4
      if (st_nxt.loopback_enable || !rts_active) begin
         st_nxt.rts_pin = ~st_nxt.rts_polarity; // R2 R4 R13
      end else begin
         st_nxt.rts_pin = st_nxt.rts_polarity; // R2 R4
      end

      // loopback: tx turns back inside, pins rest at idle
      st_nxt.txd_pin = st_nxt.loopback_enable ? 1'b1 : TXD_I; // R13
      st_nxt.rxd_int = st_nxt.loopback_enable ? TXD_I : rxd_sync; // R13

      st_nxt.irq = st_nxt.cts_change_flag & st_nxt.modem_interrupt_enable; // R8
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_r <= UMF_STATE_RST; // R10 R11
      end else begin
         st_r <= st_nxt;
      end
   end

   assign S_AXI_AWREADY = st_r.awready;
   assign S_AXI_WREADY = st_r.wready;
   assign S_AXI_BVALID = st_r.bvalid;
   assign S_AXI_BRESP = st_r.bresp;
   assign S_AXI_ARREADY = st_r.arready;
   assign S_AXI_RVALID = st_r.rvalid;
   assign S_AXI_RDATA = st_r.rdata;
   assign S_AXI_RRESP = st_r.rresp;
   assign RTS_O = st_r.rts_pin;
   assign TXD_O = st_r.txd_pin;
   assign RXD_O = st_r.rxd_int;
   assign CTS_ACTIVE_O = st_r.cts_active;
   assign IRQ_O = st_r.irq;

endmodule : umf_modem

// ---- src/umf_pkg.sv ----
package umf_pkg;

   localparam int UMF_AW = 8;

   // register byte offsets
   localparam logic [UMF_AW-1:0] UMF_OFF_INT_ENABLE = 8'h04;
   localparam logic [UMF_AW-1:0] UMF_OFF_INT_STATUS = 8'h08;
   localparam logic [UMF_AW-1:0] UMF_OFF_INT_CLEAR = 8'h0c;
   localparam logic [UMF_AW-1:0] UMF_OFF_MODEM_CONTROL = 8'h10;
   localparam logic [UMF_AW-1:0] UMF_OFF_MODEM_STATUS = 8'h14;

   // modem_control fields
   localparam int UMF_MC_RTS_CTL = 1;
   localparam int UMF_MC_LOOPBACK = 4;
   localparam int UMF_MC_RTS_POL = 9;
   localparam int UMF_MC_RTS_LEVEL = 13;

   // modem_status fields
   localparam int UMF_MS_CTS_FLAG = 0;
   localparam int UMF_MS_CTS_LEVEL = 4;
   localparam int UMF_MS_CTS_POL = 8;

   // interrupt enable / status / clear fields
   localparam int UMF_IE_MODEM = 0;
   localparam int UMF_IE_AUTO_RTS = 12;

   localparam logic [31:0] UMF_MODEM_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] UMF_MODEM_STATUS_RST = 32'h0000_0000;

   // cycles until the cts synchroniser output reflects the pin after reset
   localparam logic [2:0] UMF_SETTLE_CYCLES = 3'h4;

   localparam logic [1:0] UMF_RESP_OKAY = 2'h0;
   localparam logic [1:0] UMF_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } umf_sync_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_held;
      logic [UMF_AW-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic rts_ctl;
      logic loopback_enable;
      logic rts_polarity;
      logic cts_polarity;
      logic cts_change_flag;
      logic modem_interrupt_enable;
      logic auto_rts_enable;
      logic rts_pin;
      logic txd_pin;
      logic rxd_int;
      logic cts_active;
      logic irq;
      logic cts_prev;
      logic [2:0] settle;
   } umf_state_s;

   localparam umf_state_s UMF_STATE_RST = '{
      rts_pin: 1'b1,
      txd_pin: 1'b1,
      rxd_int: 1'b1,
      default: '0
   };

endpackage : umf_pkg

// ---- src/umf_sync.sv ----
`timescale 1ns/10ps
module umf_sync
   import umf_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous level in, filtered level out
   input wire logic async_i,
   output logic level_o
);
   umf_sync_s st_r;
   umf_sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = async_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // a change only counts once the later two stages agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.q;

endmodule : umf_sync

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import umf_pkg::*;
   logic CLK_I = 0, SYS_RST_I = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
   logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, TXD_I = 1, RXD_I = 1, AUTO_RTS_I = 0;
   logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
   logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic RTS_O, CTS_I, TXD_O, RXD_O, CTS_ACTIVE_O, IRQ_O, cts_req = 0;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   umf_modem umf_modem_inst (.*);
   umf_partner umf_partner_inst (.clk_i(CLK_I), .rts_i(RTS_O), .cts_req_i(cts_req),
      .cts_o(CTS_I));
   initial forever #4 CLK_I = ~CLK_I;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge CLK_I);
   endtask : w
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] r = UMF_RESP_OKAY);
      @(posedge CLK_I);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1;
      S_AXI_WVALID <= 1;
      S_AXI_BREADY <= 1;
      do begin
         @(posedge CLK_I);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      end while (S_AXI_BVALID !== 1);
      S_AXI_BREADY <= 0;
      chk("bresp", r, S_AXI_BRESP);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] r = UMF_RESP_OKAY);
      @(posedge CLK_I);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1;
      S_AXI_RREADY <= 1;
      do begin
         @(posedge CLK_I);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      end while (S_AXI_RVALID !== 1);
      S_AXI_RREADY <= 0;
      chk("rdata", e, S_AXI_RDATA);
      chk("rresp", r, S_AXI_RRESP);
   endtask : rd
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   // ceiling well above the roughly 160 cycles the sequence needs
   always @(posedge CLK_I) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      w(12);
      SYS_RST_I <= 0;
      w(10);
      chk("rts", 1, RTS_O);
      // pin level bit reads 1 here: inactive low-true rts sits high
      rd(8'h10, 32'h0000_2000);
      rd(8'h14, 0);
      rd(8'h20, 0, UMF_RESP_SLVERR);
      wr(8'h20, 1, UMF_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         wr(8'h10, {22'h0, i[1], 7'h0, i[0], 1'b0});
         chk("rts", i[0] ? i[1] : !i[1], RTS_O);
         rd(8'h10, {18'h0, i[0] ~^ i[1], 3'h0, i[1], 7'h0, i[0], 1'b0});
      end
      wr(8'h10, 32'h212);
      TXD_I <= 0;
      w(3);
      chk("rts", 0, RTS_O);
      chk("txd", 1, TXD_O);
      chk("rxd", 0, RXD_O);
      rd(8'h10, 32'h212);
      wr(8'h10, 32'h202);
      w(2);
      chk("txd", 0, TXD_O);
      TXD_I <= 1;
      RXD_I <= 0;
      w(8);
      chk("rxd", 0, RXD_O);
      RXD_I <= 1;
      wr(8'h04, 32'h1000);
      AUTO_RTS_I <= 1;
      w(3);
      chk("rts", 1, RTS_O);
      AUTO_RTS_I <= 0;
      cts_req <= 1;
      w(12);
      chk("rts", 0, RTS_O);
      chk("irq", 0, IRQ_O);
      rd(8'h08, 1);
      rd(8'h14, 32'h11);
      wr(8'h0c, 1);
      rd(8'h14, 32'h10);
      wr(8'h04, 1);
      cts_req <= 0;
      w(12);
      chk("irq", 1, IRQ_O);
      wr(8'h14, 0);
      rd(8'h14, 1);
      wr(8'h14, 1);
      w(2);
      chk("irq", 0, IRQ_O);
      chk("cts_act", 1, CTS_ACTIVE_O);
      wr(8'h14, 32'h100);
      w(2);
      chk("cts_act", 0, CTS_ACTIVE_O);
      rd(8'h14, 32'h100);
      end_sim();
   end
endmodule : testbench

// ---- tb/umf_modem_assertions.sv ----
`timescale 1ns/10ps
module umf_modem_checker
   import umf_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // bus
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic [umf_pkg::UMF_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   // pins
   input wire logic RTS_O,
   input wire logic CTS_I,
   input wire logic TXD_O,
   input wire logic TXD_I,
   input wire logic AUTO_RTS_I,
   input wire logic CTS_ACTIVE_O,
   input wire logic IRQ_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // cycles since cts last moved; synchroniser delay must fit this window
   logic [3:0] quiet_r;
   logic cts_d_r;
   always_ff @(posedge CLK_I) begin
      cts_d_r <= CTS_I;
      if (SYS_RST_I || CTS_I != cts_d_r) quiet_r <= 4'h0;
      else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
   end
   property p_rd; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_bad; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h20
      |=> S_AXI_RRESP == UMF_RESP_SLVERR && S_AXI_RDATA == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read answered");
   property p_wr; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##2 S_AXI_BVALID; endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_tx; !TXD_O |-> !$past(TXD_I); endproperty
   a_tx: assert property (p_tx) else $error("txd low without cause");
   property p_rts; $changed(RTS_O) |-> $rose(S_AXI_BVALID) ||
      $past(AUTO_RTS_I) != $past(AUTO_RTS_I, 2); endproperty
   a_rts: assert property (p_rts) else $error("rts moved without cause");
   property p_clr; $fell(IRQ_O) |-> S_AXI_BVALID || $past(S_AXI_BVALID); endproperty
   a_clr: assert property (p_clr) else $error("irq dropped without write");
   property p_set; $rose(IRQ_O) |-> quiet_r < 4'ha || S_AXI_BVALID || $past(S_AXI_BVALID);
   endproperty
   a_set: assert property (p_set) else $error("irq rose without cause");
   property p_act; $changed(CTS_ACTIVE_O) |-> quiet_r < 4'ha || S_AXI_BVALID ||
      $past(S_AXI_BVALID); endproperty
   a_act: assert property (p_act) else $error("cts active moved without cause");
endmodule : umf_modem_checker
bind umf_modem umf_modem_checker umf_modem_checker_inst (.*);

// ---- tb/umf_partner.sv ----
`timescale 1ns/10ps
module umf_partner (
   // clock
   input wire logic clk_i,
   // handshake pins
   input wire logic rts_i,
   input wire logic cts_req_i,
   output logic cts_o
);
   // cts moves just after an edge, never in step with a bus access
   initial cts_o = 1'b0;
   always @(posedge clk_i) begin
      cts_o <= cts_req_i;
   end
endmodule : umf_partner
